// *** src/exec_pkg.sv ***
// Shared constants, encodings and carrier types for the bit, literal and call execution block
package exec_pkg;
   localparam int PC_WIDTH        = 13;
   localparam int DATA_WIDTH      = 8;
   localparam int FILE_ADDR_WIDTH = 7;
   localparam int INSTR_WIDTH     = 14;
   localparam int STACK_DEPTH     = 8;
   localparam int APB_ADDR_WIDTH  = 8;
   localparam int CALL_TARGET_WIDTH = 11;
   localparam int BIT_INDEX_LSB     = 7;
   localparam int PAGE_BITS_LSB     = 3;
   localparam int STACK_COUNT_LSB   = 16;

   // Opcode fields of a 14-bit instruction word
   localparam logic [3:0]  OPC_BIT_CLEAR      = 4'h4;
   localparam logic [3:0]  OPC_BIT_SET        = 4'h5;
   localparam logic [3:0]  OPC_SKIP_CLEAR     = 4'h6;
   localparam logic [3:0]  OPC_SKIP_SET       = 4'h7;
   localparam logic [5:0]  OPC_LITERAL_AND    = 6'h39;
   localparam logic [2:0]  OPC_CALL           = 3'h4;
   localparam logic [6:0]  OPC_FILE_CLEAR     = 7'h03;
   localparam logic [6:0]  OPC_WORK_CLEAR     = 7'h02;
   localparam logic [13:0] OPC_WATCHDOG_CLEAR = 14'h0064;

   // Register map, byte addresses
   localparam logic [7:0] REG_CTRL          = 8'h00;
   localparam logic [7:0] REG_WORK          = 8'h04;
   localparam logic [7:0] REG_STATUS        = 8'h08;
   localparam logic [7:0] REG_PC_HIGH_LATCH = 8'h0C;
   localparam logic [7:0] REG_PC            = 8'h10;
   localparam logic [7:0] REG_STACK         = 8'h14;

   localparam int STATUS_ZERO_BIT       = 0;
   localparam int STATUS_POWER_DOWN_BIT = 3;
   localparam int STATUS_TIMEOUT_BIT    = 4;
   localparam int CTRL_RUN_BIT          = 0;

   localparam logic [12:0] PC_RESET   = 13'h0000;
   localparam logic        FLAG_RESET = 1'b1;

   typedef enum logic [3:0] {OP_NONE, OP_BIT_CLEAR, OP_BIT_SET, OP_SKIP_SET, OP_SKIP_CLEAR,
                             OP_LITERAL_AND, OP_FILE_CLEAR, OP_WORK_CLEAR, OP_CALL,
                             OP_WATCHDOG_CLEAR} op_type;
   typedef enum logic {ST_EXEC, ST_FLUSH} exec_state_type;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } apb_rsp_type;

   typedef struct packed {
      logic       we;
      logic [6:0] addr;
      logic [7:0] data;
   } file_wr_type;

   typedef struct packed {
      logic counter_clear;
      logic prescaler_clear;
   } watchdog_type;
endpackage

// *** src/bit_field_unit.sv ***
// Bit select and single-bit force on a file register byte
`timescale 1ns/10ps
module bit_field_unit #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0]         i_data,
   input  wire logic [$clog2(WIDTH)-1:0] i_bit_index,
   input  wire logic                     i_set,
   output logic [WIDTH-1:0]              o_result,
   output logic                          o_bit
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         // Only the indexed bit is forced, all others pass through
         assign o_result[g] = (i_bit_index == g) ? i_set : i_data[g];
      end
   endgenerate

   assign o_bit = i_data[i_bit_index];
endmodule

// *** src/return_stack.sv ***
// Circular hardware return stack, push side
`timescale 1ns/10ps
module return_stack #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 13
) (
   input  wire logic                       i_ref_clk,
   input  wire logic                       i_reset,
   input  wire logic                       i_clk_en,
   input  wire logic                       i_push,
   input  wire logic [WIDTH-1:0]           i_data,
   output logic      [WIDTH-1:0]           o_top,
   output logic      [$clog2(DEPTH+1)-1:0] o_count
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0]  mem;
      logic [$clog2(DEPTH)-1:0]     ptr;
      logic [$clog2(DEPTH+1)-1:0]   count;
   } stack_state_type;

   stack_state_type q;
   stack_state_type d;
   logic [$clog2(DEPTH)-1:0] top_index;

   // Overflow wraps and overwrites the oldest entry, no error is raised
   always_comb
   begin
      d = q;
      if (i_push)
      begin
         d.mem[q.ptr] = i_data;
         d.ptr = q.ptr + 1'b1;
         if (q.count != DEPTH[$clog2(DEPTH+1)-1:0])
            d.count = q.count + 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
         q <= '0;
      else if (i_clk_en)
         q <= d;
   end

   assign top_index = q.ptr - 1'b1;
   assign o_top = q.mem[top_index];
   assign o_count = q.count;
endmodule

// *** src/bit_literal_call_exec.sv ***
// Execution unit for bit, literal-and, clear, call and watchdog-clear instructions with APB registers
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/10ps
module bit_literal_call_exec #(
   parameter int STACK_DEPTH = exec_pkg::STACK_DEPTH
) (
   input  wire logic                                  i_ref_clk,
   input  wire logic                                  i_reset,
   input  wire logic                                  i_clk_en,
   input  wire exec_pkg::apb_req_type                 i_apb,
   output exec_pkg::apb_rsp_type                      o_apb,
   input  wire logic [exec_pkg::INSTR_WIDTH-1:0]      i_instr,
   input  wire logic                                  i_instr_valid,
   input  wire logic [exec_pkg::DATA_WIDTH-1:0]       i_file_rdata,
   output exec_pkg::file_wr_type                      o_file_wr,
   output exec_pkg::watchdog_type                     o_watchdog,
   output logic      [exec_pkg::PC_WIDTH-1:0]         o_pc,
   output logic                                       o_discard
);
   import exec_pkg::*;

   typedef struct packed {
      exec_state_type state;
      logic           flush_advance;
      logic           run;
      logic [7:0]     work;
      logic           zero;
      logic           power_down;
      logic           timeout;
      logic [4:0]     pc_high_latch;
      logic [12:0]    pc;
      file_wr_type    file_wr;
      watchdog_type   watchdog;
      logic           discard;
      apb_rsp_type    apb;
   } exec_regs_type;

   localparam exec_regs_type STATE_RESET = '{state: ST_EXEC, pc: PC_RESET, timeout: FLAG_RESET,
                                            power_down: FLAG_RESET, default: '0};

   exec_regs_type q;
   exec_regs_type d;

   op_type      op;
   logic        fire;
   logic        call_push;
   logic [6:0]  f_addr;
   logic [2:0]  bit_index;
   logic [7:0]  literal;
   logic [7:0]  bit_result;
   logic        bit_value;
   logic [7:0]  and_result;
   logic [12:0] pc_next;
   logic [12:0] call_target;
   logic [12:0] stack_top;
   logic [$clog2(STACK_DEPTH+1)-1:0] stack_count;
   logic        apb_access;
   logic [31:0] read_data;

   function automatic op_type decode_op(input logic [13:0] instr);
      op_type r;
      r = OP_NONE;
      if (instr == OPC_WATCHDOG_CLEAR)
         r = OP_WATCHDOG_CLEAR;
      else if (instr[13:7] == OPC_FILE_CLEAR)
         r = OP_FILE_CLEAR;
      else if (instr[13:7] == OPC_WORK_CLEAR)
         r = OP_WORK_CLEAR;
      else if (instr[13:8] == OPC_LITERAL_AND)
         r = OP_LITERAL_AND;
      else if (instr[13:11] == OPC_CALL)
         r = OP_CALL;
      else if (instr[13:10] == OPC_BIT_CLEAR)
         r = OP_BIT_CLEAR;
      else if (instr[13:10] == OPC_BIT_SET)
         r = OP_BIT_SET;
      else if (instr[13:10] == OPC_SKIP_CLEAR)
         r = OP_SKIP_CLEAR;
      else if (instr[13:10] == OPC_SKIP_SET)
         r = OP_SKIP_SET;
      return r;
   endfunction

   function automatic logic reg_hit(input logic [7:0] addr);
      return addr == REG_CTRL || addr == REG_WORK || addr == REG_STATUS ||
             addr == REG_PC_HIGH_LATCH || addr == REG_PC || addr == REG_STACK;
   endfunction

   assign op          = decode_op(i_instr);
   assign fire        = i_clk_en && q.run && q.state == ST_EXEC && i_instr_valid;
   assign f_addr      = i_instr[FILE_ADDR_WIDTH-1:0];
   assign bit_index   = i_instr[BIT_INDEX_LSB+2:BIT_INDEX_LSB];
   assign literal     = i_instr[DATA_WIDTH-1:0];
   assign and_result  = q.work & literal;
   assign pc_next     = q.pc + 13'h0001;
   assign call_target = {q.pc_high_latch[PAGE_BITS_LSB+1:PAGE_BITS_LSB], i_instr[CALL_TARGET_WIDTH-1:0]};
   assign call_push   = fire && op == OP_CALL;
   assign apb_access  = i_apb.psel && i_apb.penable;

   bit_field_unit #(
      .WIDTH (DATA_WIDTH)
   ) u_bit_field (
      .i_data      (i_file_rdata),
      .i_bit_index (bit_index),
      .i_set       (op == OP_BIT_SET),
      .o_result    (bit_result),
      .o_bit       (bit_value)
   );

   // return address push; frozen with the rest while the enable is low
   return_stack #(
      .DEPTH (STACK_DEPTH),
      .WIDTH (PC_WIDTH)
   ) u_stack (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .i_clk_en  (i_clk_en),
      .i_push    (call_push),
      .i_data    (pc_next),
      .o_top     (stack_top),
      .o_count   (stack_count)
   );

   always_comb
   begin
      read_data = 32'h00000000;
      unique case (i_apb.paddr)
         REG_CTRL:          read_data[CTRL_RUN_BIT] = q.run;
         REG_WORK:          read_data[7:0] = q.work;
         REG_STATUS:
         begin
            read_data[STATUS_ZERO_BIT]       = q.zero;
            read_data[STATUS_POWER_DOWN_BIT] = q.power_down;
            read_data[STATUS_TIMEOUT_BIT]    = q.timeout;
         end
         REG_PC_HIGH_LATCH: read_data[4:0] = q.pc_high_latch;
         REG_PC:            read_data[12:0] = q.pc;
         REG_STACK:
         begin
            read_data[12:0] = stack_top;
            read_data[STACK_COUNT_LSB+$bits(stack_count)-1:STACK_COUNT_LSB] = stack_count;
         end
         default:           read_data = 32'h00000000;
      endcase
   end

   always_comb
   begin
      d = q;
      d.file_wr.we = 1'b0;
      d.watchdog = '0;
      d.apb = '0;

      // One wait state: answer is prepared in the first access cycle, write lands when pready is seen
      if (apb_access && !q.apb.pready)
      begin
         d.apb.pready  = 1'b1;
         d.apb.pslverr = !reg_hit(i_apb.paddr);
         d.apb.prdata  = read_data;
      end
      if (apb_access && q.apb.pready && i_apb.pwrite)
      begin
         unique case (i_apb.paddr)
            REG_CTRL:          d.run = i_apb.pwdata[CTRL_RUN_BIT];
            REG_WORK:          d.work = i_apb.pwdata[7:0];
            REG_STATUS:
            begin
               d.zero       = i_apb.pwdata[STATUS_ZERO_BIT];
               d.power_down = i_apb.pwdata[STATUS_POWER_DOWN_BIT];
               d.timeout    = i_apb.pwdata[STATUS_TIMEOUT_BIT];
            end
            REG_PC_HIGH_LATCH: d.pc_high_latch = i_apb.pwdata[4:0];
            default:           d.run = q.run;
         endcase
      end

      // Execution comes after the bus write so that the instruction wins a same-cycle conflict
      if (fire)
      begin
         d.pc = pc_next;
         unique case (op)
            OP_BIT_CLEAR, OP_BIT_SET:
            begin
               d.file_wr.we   = 1'b1;
               d.file_wr.addr = f_addr;
               d.file_wr.data = bit_result;
            end
            OP_SKIP_SET:
            begin
               if (bit_value)
               begin
                  d.state = ST_FLUSH;
                  d.flush_advance = 1'b1;
               end
            end
            OP_SKIP_CLEAR:
            begin
               if (!bit_value)
               begin
                  d.state = ST_FLUSH;
                  d.flush_advance = 1'b1;
               end
            end
            OP_LITERAL_AND:
            begin
               d.work = and_result;
               d.zero = and_result == 8'h00;
            end
            OP_FILE_CLEAR:
            begin
               d.file_wr.we   = 1'b1;
               d.file_wr.addr = f_addr;
               d.file_wr.data = 8'h00;
               d.zero         = 1'b1;
            end
            OP_WORK_CLEAR:
            begin
               d.work = 8'h00;
               d.zero = 1'b1;
            end
            OP_CALL:
            begin
               d.pc = call_target;
               d.state = ST_FLUSH;
               d.flush_advance = 1'b0;
            end
            OP_WATCHDOG_CLEAR:
            begin
               d.watchdog.counter_clear   = 1'b1;
               d.watchdog.prescaler_clear = 1'b1;
               d.timeout    = 1'b1;
               d.power_down = 1'b1;
            end
            default:
            begin
               // Instructions outside this group only advance the program counter
               d.pc = pc_next;
            end
         endcase
      end
      else if (q.run && q.state == ST_FLUSH && i_instr_valid)
      begin
         // second cycle executes as a NOP
         d.state = ST_EXEC;
         if (q.flush_advance)
            d.pc = pc_next;
      end
      d.discard = d.state == ST_FLUSH;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
         q <= STATE_RESET;
      else if (i_clk_en)
         q <= d;
   end

   assign o_apb      = q.apb;
   assign o_file_wr  = q.file_wr;
   assign o_watchdog = q.watchdog;
   assign o_pc       = q.pc;
   assign o_discard  = q.discard;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_reset);

   a_bit_clear_write: assert property (
      fire && op == OP_BIT_CLEAR |=> o_file_wr.we && o_file_wr.addr == $past(f_addr)
         && o_file_wr.data == ($past(i_file_rdata) & ~(8'h01 << $past(bit_index))))
      else $error("bit clear wrote wrong value");

   a_bit_set_write: assert property (
      fire && op == OP_BIT_SET |=> o_file_wr.we && o_file_wr.addr == $past(f_addr)
         && o_file_wr.data == ($past(i_file_rdata) | (8'h01 << $past(bit_index))))
      else $error("bit set wrote wrong value");

   a_literal_and_work: assert property (
      fire && op == OP_LITERAL_AND |=> q.work == ($past(q.work) & $past(literal)))
      else $error("literal and result wrong");

   a_skip_set_taken: assert property (
      fire && op == OP_SKIP_SET && bit_value |=> o_discard && o_pc == $past(pc_next))
      else $error("skip on set not taken");

   a_skip_set_falls: assert property (
      fire && op == OP_SKIP_SET && !bit_value |=> !o_discard)
      else $error("skip on set taken wrongly");

   a_skip_clear_taken: assert property (
      fire && op == OP_SKIP_CLEAR |=> o_discard == !$past(bit_value))
      else $error("skip on clear wrong");

   a_file_clear_zero: assert property (
      fire && op == OP_FILE_CLEAR |=> o_file_wr.we && o_file_wr.data == 8'h00 && q.zero)
      else $error("file clear failed");

   a_work_clear_zero: assert property (
      fire && op == OP_WORK_CLEAR |=> q.work == 8'h00 && q.zero && !o_file_wr.we)
      else $error("work clear failed");

   a_call_push_return: assert property (
      fire && op == OP_CALL |=> stack_top == $past(q.pc) + 13'h0001)
      else $error("call pushed wrong return address");

   a_call_target_page: assert property (
      fire && op == OP_CALL |=> o_pc == {$past(q.pc_high_latch[4:3]), $past(i_instr[10:0])})
      else $error("call target or page wrong");

   a_call_two_cycles: assert property (
      fire && op == OP_CALL |=> o_discard ##1 (!o_discard || !$past(i_clk_en && i_instr_valid)))
      else $error("call not two cycles");

   a_watchdog_clear_flags: assert property (
      fire && op == OP_WATCHDOG_CLEAR |=> o_watchdog.counter_clear && o_watchdog.prescaler_clear
         && q.timeout && q.power_down)
      else $error("watchdog clear incomplete");

   a_flags_kept: assert property (
      fire && (op == OP_BIT_CLEAR || op == OP_BIT_SET || op == OP_CALL) && !apb_access
         |=> $stable(q.zero) && $stable(q.timeout) && $stable(q.power_down))
      else $error("status flags disturbed");

   a_single_cycle_ops: assert property (
      fire && (op == OP_LITERAL_AND || op == OP_WORK_CLEAR || op == OP_FILE_CLEAR)
         |=> !o_discard && o_pc == $past(pc_next))
      else $error("single cycle op stalled");

   c_call_seen: cover property (fire && op == OP_CALL ##1 o_discard);
   c_skip_taken: cover property (fire && op == OP_SKIP_CLEAR && !bit_value);
   c_watchdog_clear: cover property (fire && op == OP_WATCHDOG_CLEAR);
   c_apb_write: cover property (apb_access && q.apb.pready && i_apb.pwrite);
endmodule

// *** dv/file_reg_model.sv ***
// Behavioural file register space that answers the execution unit
`timescale 1ns/10ps
module file_reg_model
(
   input  wire logic                  i_ref_clk,
   input  wire logic [6:0]            i_addr,
   input  wire exec_pkg::file_wr_type i_wr,
   output logic      [7:0]            o_rdata
);
   import exec_pkg::*;
   logic [7:0] mem [128];

   // Scrambled start contents so that every bit test sees both values
   initial
   begin
      for (int i = 0; i < 128; i++)
         mem[i] = 8'(i * 29) ^ 8'hA5;
   end

   // Read is combinational, same cycle as the instruction slot
   assign o_rdata = mem[i_addr];

   always @(posedge i_ref_clk)
   begin
      if (i_wr.we === 1'b1)
         mem[i_wr.addr] <= i_wr.data;
   end
endmodule

// *** dv/test_bit_literal_call_exec.sv ***
// Self-checking random testbench of the bit, literal, clear, call and watchdog-clear unit
`timescale 1ns/10ps
module test_bit_literal_call_exec;
   import exec_pkg::*;
   logic         clk, rst, valid, err, z, to, pd, hit, ewe, skip, call;
   logic [13:0]  instr, wrd;
   apb_req_type  req;
   apb_rsp_type  rsp;
   file_wr_type  fw;
   watchdog_type wd;
   logic [12:0]  pc, epc, enext;
   logic         disc, ce;
   logic [7:0]   rdat, w, cur, k8, edat;
   logic [31:0]  seed, rv, rv2, rd;
   logic [10:0]  k11;
   logic [4:0]   latch;
   logic [3:0]   sel, cnt;
   logic [2:0]   b;
   logic [6:0]   f;
   int           fail_count, cmp_count;

   bit_literal_call_exec i_bit_literal_call_exec (.i_ref_clk(clk), .i_reset(rst), .i_clk_en(ce), .i_apb(req),
      .o_apb(rsp), .i_instr(instr), .i_instr_valid(valid), .i_file_rdata(rdat), .o_file_wr(fw), .o_watchdog(wd),
      .o_pc(pc), .o_discard(disc));
   file_reg_model i_file_reg_model (.i_ref_clk(clk), .i_addr(instr[6:0]), .i_wr(fw), .o_rdata(rdat));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task report_and_stop();
      if (fail_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd_in, output logic [31:0] rd_o,
            output logic err_o);
      int n;
      @(posedge clk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= wr;
      req.paddr   <= a;
      req.pwdata  <= wd_in;
      @(posedge clk);
      req.penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (rsp.pready !== 1'b1 && n < 20);
      rd_o  = rsp.prdata;
      err_o = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      if (rsp.pready !== 1'b1)
      begin
         chk("pready", 32'h1, {31'h0, rsp.pready});
         report_and_stop();
      end
   endtask

   // One valid instruction slot; outputs are looked at once the taking edge has landed
   task exec(input logic [13:0] word);
      @(posedge clk);
      instr <= word;
      valid <= 1'b1;
      @(posedge clk);
      valid <= 1'b0;
      #1;
   endtask

   initial
   begin
      seed = 32'h6E75;
      fail_count = 0;
      cmp_count = 0;
      rst = 1'b1;
      ce = 1'b1;
      valid = 1'b0;
      instr = 14'h0000;
      req = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // Not yet running: the slot must be ignored
      exec({OPC_BIT_SET, 3'h0, 7'h00});
      chk("pc_idle", 32'h0, {19'h0, pc});
      apb(1'b0, REG_STATUS, 32'h0, rd, err);
      chk("status_reset", 32'h18, rd);
      apb(1'b0, 8'h40, 32'h0, rd, err);
      chk("unmapped_err", 32'h1, {31'h0, err});
      chk("unmapped_data", 32'h0, rd);
      apb(1'b1, REG_PC, 32'h0000_1234, rd, err);
      apb(1'b0, REG_PC, 32'h0, rd, err);
      chk("pc_read_only", 32'h0, rd);
      apb(1'b1, REG_CTRL, 32'h1, rd, err);
      // Enable low: a valid slot must leave all state frozen
      ce <= 1'b0;
      exec({OPC_WORK_CLEAR, 7'h00});
      chk("pc_frozen", 32'h0, {19'h0, pc});
      chk("frozen_we", 32'h0, {30'h0, fw.we, disc});
      @(posedge clk);
      ce <= 1'b1;
      // A word from outside the group only moves the program counter
      exec(14'h3FFF);
      chk("pc_other", 32'h1, {19'h0, pc});
      chk("other_we", 32'h0, {30'h0, fw.we, disc});
      epc = 13'h0001;
      cnt = 4'h0;
      for (int n = 0; n < 120; n++)
      begin
         rv  = rnd();
         rv2 = rnd();
         {w, k8, f, b, z, pd, to} = rv[28:0];
         {k11, latch} = rv2[15:0];
         sel = 4'(rv2[19:16] % 4'd9);
         // Boundary operands first: last register, top bit, full target
         if (n < 9)
            {sel, f, b, k11, latch} = {4'(n), 7'h7F, 3'h7, 11'h7FF, 5'h18};
         apb(1'b1, REG_WORK, {24'h0, w}, rd, err);
         apb(1'b1, REG_STATUS, {27'h0, to, pd, 2'b00, z}, rd, err);
         apb(1'b1, REG_PC_HIGH_LATCH, {27'h0, latch}, rd, err);
         cur = i_file_reg_model.mem[f];
         hit = cur[b];
         {ewe, edat, skip, call} = '0;
         case (sel)
            4'd0: {wrd, ewe, edat} = {OPC_BIT_CLEAR, b, f, 1'b1, cur & ~(8'h01 << b)};
            4'd1: {wrd, ewe, edat} = {OPC_BIT_SET, b, f, 1'b1, cur | (8'h01 << b)};
            4'd2: {wrd, skip} = {OPC_SKIP_SET, b, f, hit};
            4'd3: {wrd, skip} = {OPC_SKIP_CLEAR, b, f, !hit};
            4'd4: {wrd, w, z} = {OPC_LITERAL_AND, k8, w & k8, (w & k8) == 8'h00};
            4'd5: {wrd, ewe, edat, z} = {OPC_FILE_CLEAR, f, 1'b1, 8'h00, 1'b1};
            4'd6: {wrd, w, z} = {OPC_WORK_CLEAR, f, 8'h00, 1'b1};
            4'd7: {wrd, to, pd} = {OPC_WATCHDOG_CLEAR, 2'b11};
            default: {wrd, call} = {OPC_CALL, k11, 1'b1};
         endcase
         enext = call ? {latch[4:3], k11} : epc + 13'd1;
         exec(wrd);
         chk("file_we", {31'h0, ewe}, {31'h0, fw.we});
         if (ewe)
            chk("file_wr", {17'h0, f, edat}, {17'h0, fw.addr, fw.data});
         chk("watchdog", (sel == 4'd7) ? 32'h3 : 32'h0, {30'h0, wd});
         chk("pc", {19'h0, enext}, {19'h0, pc});
         chk("discard", {31'h0, skip | call}, {31'h0, disc});
         // The slot after a skip or call carries a write that must not happen
         if (skip | call)
         begin
            exec({OPC_BIT_SET, b, f});
            chk("flush_we", 32'h0, {31'h0, fw.we});
            chk("flush_pc", {19'h0, call ? enext : enext + 13'd1}, {19'h0, pc});
            chk("flush_end", 32'h0, {31'h0, disc});
            enext = call ? enext : enext + 13'd1;
         end
         apb(1'b0, REG_WORK, 32'h0, rd, err);
         chk("work", {24'h0, w}, rd);
         apb(1'b0, REG_STATUS, 32'h0, rd, err);
         chk("status", {27'h0, to, pd, 2'b00, z}, rd);
         if (call)
         begin
            cnt = (cnt == 4'd8) ? 4'd8 : cnt + 4'd1;
            apb(1'b0, REG_STACK, 32'h0, rd, err);
            chk("stack", {12'h0, cnt, 3'h0, epc + 13'd1}, rd);
         end
         epc = enext;
      end
      report_and_stop();
   end
endmodule
